//--- rtl/scm_ctrl.sv
/*
  Mode controller of a two-channel sampling converter serial port.
  Assumes cs_n, sclk and din come from an outside host and are resynced;
  the conversion result word arrives from the analog core via result.
*/
`timescale 1ns/1ps
// Functional notes
// - Fully powered after one complete dummy cycle
// - Track resumes on fifth fall when waking, else on rise after 13th
// - Track acquires channel picked this cycle
// - Rise after edge 13 selects normal
// - Rise in 10..12 enters chain, output off
// - Rise at 12 enters chain, data invalid
// - Start in any mode, hold state
// - Normal result stored and driven out
// - Chain mode shifts input through register
// - Equal channel/keep bits return to normal
// - Chain dummy rise 10..12 restores normal
// - Every chain word, the first one too, configures
// - Chain dummy exit and chain entry at 12 mark output invalid
// - Sample input on falls, use bits 3,4
// - Output: two zeros, chan, mode, result
// - Mode flag equals channel means normal
// - Rise in 2..9 enters power-down
module scm_ctrl
  import scm_pkg::*;
(
  input  wire logic                    clk,         // 125 MHz clock
  input  wire logic                    srst,        // Sync reset
  input  wire logic                    cs_n,        // Chip select pin
  input  wire logic                    sclk,        // Serial clock pin
  input  wire logic                    din,         // Serial input pin
  input  wire logic [scm_pkg::RES_BITS-1:0] result, // Converted value
  input  wire logic [1:0]              init_mode,   // Start mode pick
  output logic                         dout_o,      // Serial out value
  output logic                         dout_oe_n,   // Out enable, low
  output logic                         track,       // Track, not hold
  output logic                         track_chan,  // Channel tracked
  output logic                         powered,     // Analog powered
  output logic [2:0]                   mode,        // Current mode
  output logic                         data_valid,  // Chain data good
  output logic                         conv_start   // Sample pulse
);
  typedef struct packed {
    scm_mode_t          mode;
    logic [4:0]         cnt;
    logic [15:0]        word;
    logic               chn_bit;
    logic               keep_bit;
    logic               next_chan;
    logic               out_bit;
    logic               oe_n;
    logic               track;
    logic               track_chan;
    logic               powered;
    logic [7:0]         pwr_cnt;
    logic               wake;
    logic               valid;
    logic               first_word;
    logic               start;
    logic               init_done;
  } scm_state_t;

  scm_state_t st_reg;
  scm_state_t st_next;
  logic cs_lvl, cs_rise, cs_fall;
  logic sk_rise, sk_fall, din_lvl;

  // Pin synchronisers
  scm_sync u_cs (.clk(clk), .srst(srst), .pin(cs_n),
                 .level(cs_lvl), .rise(cs_rise), .fall(cs_fall));
  scm_sync u_sk (.clk(clk), .srst(srst), .pin(sclk),
                 .level(), .rise(sk_rise), .fall(sk_fall));
  scm_sync u_di (.clk(clk), .srst(srst), .pin(din),
                 .level(din_lvl), .rise(), .fall());

  // Fall-count window test, used by the power-down and chain decisions
  function automatic logic in_win(input logic [4:0] c,
                                  input logic [4:0] lo,
                                  input logic [4:0] hi);
    in_win = (c >= lo) && (c < hi);
  endfunction : in_win

  // Next mode from the fall count at the chip-select rise
  always_comb begin
    st_next       = st_reg;
    st_next.start = 1'b0;
    // Strap caught once after reset release
    if (!st_reg.init_done) begin
      st_next.init_done = 1'b1;
      case (init_mode)
        2'h1:    st_next.mode = SCM_PDOWN;
        2'h2:    st_next.mode = SCM_CHAIN;
        default: st_next.mode = SCM_NORMAL;
      endcase
      st_next.powered = (init_mode != 2'h1);
    end
    // Power-up timer: one dummy cycle's worth of time
    if (st_reg.pwr_cnt != 8'h00) begin
      st_next.pwr_cnt = st_reg.pwr_cnt - 8'h01;
      if (st_reg.pwr_cnt == 8'h01) begin
        st_next.powered = 1'b1;
      end
    end
    if (cs_fall) begin
      st_next.cnt        = 5'h00;
      st_next.start      = 1'b1;
      st_next.track      = 1'b0;
      st_next.oe_n       = 1'b0;
      // Chain mode shows its stored top bit, normal its leading zero
      st_next.out_bit    = (st_reg.mode == SCM_CHAIN) ?
                           st_reg.word[15] : 1'b0;
      st_next.wake       = (st_reg.mode == SCM_PDOWN) | ~st_reg.powered;
      st_next.first_word = 1'b0;
      if (st_reg.mode == SCM_PDOWN) begin
        st_next.pwr_cnt = PWRUP_CNT;
      end
      // Normal load: zeros, channel, mode flag, result
      if (st_reg.mode != SCM_CHAIN) begin
        st_next.word = {2'b00, st_reg.next_chan,
                        st_reg.next_chan, result};
      end
    end else if (!cs_lvl && sk_fall && st_reg.cnt != 5'h1f) begin
      st_next.cnt = st_reg.cnt + 5'h01;
      // Shift out MSB first, input in at the bottom
      st_next.out_bit = st_reg.word[14];
      st_next.word    = {st_reg.word[14:0], din_lvl};
      if (st_reg.cnt + 5'h01 == EDGE_CHN) begin
        st_next.chn_bit = din_lvl;
      end
      if (st_reg.cnt + 5'h01 == EDGE_KEEP) begin
        st_next.keep_bit = din_lvl;
      end
      if (st_reg.wake && st_reg.cnt + 5'h01 == EDGE_TRACK) begin
        st_next.track      = 1'b1;
        st_next.track_chan = st_reg.chn_bit;
      end
      if (st_reg.cnt + 5'h01 == EDGE_LAST) begin
        st_next.oe_n = 1'b1;
      end
    end else if (!cs_lvl && sk_rise && st_reg.cnt == EDGE_CH_BAD) begin
      st_next.track      = 1'b1;
      st_next.track_chan = st_reg.chn_bit;
    end
    if (cs_rise) begin
      st_next.oe_n = 1'b1;
      if (in_win(st_reg.cnt, EDGE_PD_LO, EDGE_CH_LO)) begin
        st_next.mode    = SCM_PDOWN;
        st_next.powered = 1'b0;
        st_next.pwr_cnt = 8'h00;
        st_next.track   = 1'b0;
      end else if (in_win(st_reg.cnt, EDGE_CH_LO, EDGE_CH_BAD)) begin
        if (st_reg.mode == SCM_CHAIN) begin
          st_next.mode      = SCM_NORMAL;
          st_next.next_chan = st_reg.chn_bit;
          st_next.valid     = 1'b0;
        end else begin
          st_next.mode       = SCM_CHAIN;
          st_next.valid      = (st_reg.cnt < EDGE_CH_HI);
          st_next.first_word = 1'b1;
        end
      end else if (st_reg.cnt >= EDGE_CH_BAD) begin
        if (st_reg.mode == SCM_CHAIN &&
            st_reg.chn_bit != st_reg.keep_bit) begin
          st_next.mode = SCM_CHAIN;
        end else begin
          st_next.mode  = SCM_NORMAL;
          st_next.valid = 1'b1;
        end
        // Channel bit caught on the third fall becomes the next channel
        st_next.next_chan = st_reg.chn_bit;
      end else if (st_reg.mode == SCM_PDOWN) begin
        // Glitch frame must not leave a power-up running
        st_next.powered = 1'b0;
        st_next.pwr_cnt = 8'h00;
        st_next.track   = 1'b0;
      end
      // Counts below two leave the mode alone
    end
  end

  // Single state register
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '{mode: SCM_NORMAL, cnt: 5'h00, word: WORD_RST,
                  chn_bit: 1'b0, keep_bit: 1'b0, next_chan: 1'b0,
                  out_bit: 1'b0, oe_n: 1'b1, track: 1'b0,
                  track_chan: 1'b0, powered: 1'b0, pwr_cnt: 8'h00,
                  wake: 1'b0, valid: 1'b0, first_word: 1'b0,
                  start: 1'b0, init_done: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign dout_o     = st_reg.out_bit;
  assign dout_oe_n  = st_reg.oe_n;
  assign track      = st_reg.track;
  assign track_chan = st_reg.track_chan;
  assign powered    = st_reg.powered;
  assign mode       = st_reg.mode;
  assign data_valid = st_reg.valid;
  assign conv_start = st_reg.start;

  // Checks
  pd_window_a: assert property (@(posedge clk) disable iff (srst)
    cs_rise && st_reg.cnt >= 5'h02 && st_reg.cnt < 5'h0a
    |=> st_reg.mode == SCM_PDOWN && st_reg.oe_n)
    else $error("power-down window missed");
  chain_entry_a: assert property (@(posedge clk) disable iff (srst)
    cs_rise && st_reg.mode == SCM_NORMAL && st_reg.cnt >= 5'h0a &&
    st_reg.cnt < 5'h0d |=> st_reg.mode == SCM_CHAIN && st_reg.oe_n)
    else $error("chain entry missed");
  chain_invalid_a: assert property (@(posedge clk) disable iff (srst)
    cs_rise && st_reg.mode == SCM_NORMAL && st_reg.cnt == 5'h0c
    |=> !st_reg.valid)
    else $error("late chain data marked valid");
  normal_late_a: assert property (@(posedge clk) disable iff (srst)
    cs_rise && st_reg.mode != SCM_CHAIN && st_reg.cnt >= 5'h0d
    |=> st_reg.mode == SCM_NORMAL)
    else $error("late rise not normal");
  chain_exit_a: assert property (@(posedge clk) disable iff (srst)
    cs_rise && st_reg.mode == SCM_CHAIN && st_reg.cnt >= 5'h0d &&
    st_reg.chn_bit == st_reg.keep_bit |=> st_reg.mode == SCM_NORMAL)
    else $error("equal bits kept chain");
  chain_dummy_a: assert property (@(posedge clk) disable iff (srst)
    cs_rise && st_reg.mode == SCM_CHAIN && st_reg.cnt >= 5'h0a &&
    st_reg.cnt < 5'h0d |=> st_reg.mode == SCM_NORMAL && !st_reg.valid)
    else $error("chain dummy exit failed");
  mode_hold_a: assert property (@(posedge clk) disable iff (srst)
    st_reg.init_done && cs_rise && st_reg.cnt < 5'h02 |=> $stable(mode))
    else $error("short frame changed mode");
  track_fifth_a: assert property (@(posedge clk) disable iff (srst)
    st_reg.wake && !cs_lvl && !cs_fall && sk_fall && st_reg.cnt == 5'h04
    |=> st_reg.track)
    else $error("track not on fifth fall");
  lead_zero_a: assert property (@(posedge clk) disable iff (srst)
    cs_fall |=> !st_reg.oe_n && (st_reg.mode == SCM_CHAIN ||
    (!st_reg.out_bit && st_reg.word[15:14] == 2'b00)))
    else $error("leading zero missing");
  pwr_up_a: assert property (@(posedge clk) disable iff (srst)
    st_reg.pwr_cnt == 8'h01 && !cs_rise |=> st_reg.powered)
    else $error("power-up not reached");

  cov_chain_c:  cover property (@(posedge clk) st_reg.mode == SCM_CHAIN);
  cov_pdown_c:  cover property (@(posedge clk) st_reg.mode == SCM_PDOWN);
  cov_wake_c:   cover property (@(posedge clk) st_reg.wake && st_reg.track);
  cov_exit_c:   cover property (@(posedge clk)
    $past(st_reg.mode) == SCM_CHAIN && st_reg.mode == SCM_NORMAL);
endmodule : scm_ctrl

//--- rtl/scm_pkg.sv
/*
  Constants and types for the serial converter mode controller.
  Assumes a single 125 MHz system clock that oversamples the serial pins.
*/
package scm_pkg;
  // Modes, one-hot
  typedef enum logic [2:0] {
    SCM_NORMAL = 3'h1,
    SCM_PDOWN  = 3'h2,
    SCM_CHAIN  = 3'h4
  } scm_mode_t;

  localparam int unsigned CLK_MHZ     = 125;
  localparam int unsigned WORD_BITS   = 16;
  localparam int unsigned RES_BITS    = 12;
  localparam int unsigned CNT_W       = 5;
  // Falling-edge counts for the mode windows, track start and output off
  localparam logic [4:0] EDGE_PD_LO   = 5'h02;
  localparam logic [4:0] EDGE_CH_LO   = 5'h0a;
  localparam logic [4:0] EDGE_CH_HI   = 5'h0c;
  localparam logic [4:0] EDGE_CH_BAD  = 5'h0d;
  localparam logic [4:0] EDGE_TRACK   = 5'h05;
  localparam logic [4:0] EDGE_LAST    = 5'h10;
  // Bit slots of the input word sampled on falling edges (1-based)
  localparam logic [4:0] EDGE_CHN     = 5'h03;
  localparam logic [4:0] EDGE_KEEP    = 5'h04;
  // Power-up time in ns and its cycle count, rounded up
  localparam int unsigned PWRUP_NS    = 1000;
  localparam int unsigned PWRUP_CYC   = (PWRUP_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0]  PWRUP_CNT   = 8'(PWRUP_CYC);
  localparam logic [15:0] WORD_RST    = 16'h0000;
endpackage : scm_pkg

//--- rtl/scm_sync.sv
/*
  Two-flop synchroniser with edge flags for the serial pins.
  Assumes pins are asynchronous to clk; edges seen after two flops.
*/
`timescale 1ns/1ps
module scm_sync (
  input  wire logic clk,      // System clock
  input  wire logic srst,     // Sync reset
  input  wire logic pin,      // Raw pin
  output logic      level,    // Synchronised level
  output logic      rise,     // One-cycle rise pulse
  output logic      fall      // One-cycle fall pulse
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } scm_sync_t;

  scm_sync_t st_reg;
  scm_sync_t st_next;

  // First flop only feeds the second
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = pin;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  // Reset to idle-high, so no spurious edge after reset
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= 3'h7;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level = st_reg.s2;
  assign rise  = st_reg.s2 & ~st_reg.s3;
  assign fall  = ~st_reg.s2 & st_reg.s3;
endmodule : scm_sync

//--- verification/scm_host.sv
/*
  Serial host model that frames cs_n, sclk and din for the mode controller.
  Assumes the 125 MHz bench clock; sclk has a 64 ns period, idles high.
*/
`timescale 1ns/1ps
module scm_host (
  input  wire logic        clk,        // System clock
  input  wire logic        dout_o,     // Device serial out
  input  wire logic        dout_oe_n,  // Device out enable, low
  input  wire logic        track,      // Device track flag
  input  wire logic        track_chan, // Device tracked channel
  input  wire logic        powered,    // Device power flag
  input  wire logic        data_valid, // Chain data flag
  input  wire logic [2:0]  mode,       // Device mode
  output logic             cs_n,       // Chip select, low active
  output logic             sclk,       // Serial clock, idle high
  output logic             din,        // Serial data to device
  output logic             done,       // Frame finished pulse
  output logic [24:0]      obs         // Frame summary
);
  // Idle levels; sclk stands still outside frames
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din  = 1'b0;
    done = 1'b0;
    obs  = '0;
  end

  // One frame of n falls; bits are caught just before each fall
  task automatic frame(input int n, input logic [15:0] w);
    logic [15:0] rx;
    logic        oe1;
    rx  = '0;
    oe1 = 1'b1;
    @(posedge clk) cs_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int k = 1; k <= n; k++) begin
      din <= w[16-k];
      repeat (4) @(posedge clk);
      rx = {rx[14:0], dout_o};
      if (k == 1) oe1 = dout_oe_n;
      sclk <= 1'b0;
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
    end
    // Rise sits well past the last fall and before any next one
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    din  <= ~din; // Released line must not look stable
    repeat (10) @(posedge clk);
    obs  <= {track_chan, data_valid, mode, dout_oe_n, powered, track,
             oe1, rx};
    done <= 1'b1;
    @(posedge clk) done <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : frame
endmodule : scm_host

//--- verification/scm_ctrl_tb.sv
/*
  Self-checking bench for the mode controller with the host model.
  Assumes the design package and a 125 MHz clock; one device, no chain.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module scm_ctrl_tb;
  import scm_pkg::*;
  localparam logic [24:0] MK_FULL = 25'h07fffff;
  localparam logic [24:0] MK_NT   = 25'h07dffff;
  localparam logic [24:0] MK_NORX = 25'h07d0000;
  logic                clk, srst, cs_n, sclk, din, dout_o, dout_oe_n;
  logic                track, track_chan, powered, data_valid, conv_start;
  logic                done, ch;
  logic [RES_BITS-1:0] result;
  logic [1:0]          init_mode;
  logic [2:0]          mode, cur;
  logic [24:0]         obs;
  logic [49:0]         ent;
  logic [49:0]         expq[$];
  logic [15:0]         stored, w;
  int                  err_count, check_count, cycles;
  int                  starts, frames;

  scm_ctrl dut (.clk(clk), .srst(srst), .cs_n(cs_n), .sclk(sclk), .din(din),
    .result(result), .init_mode(init_mode), .dout_o(dout_o),
    .dout_oe_n(dout_oe_n), .track(track), .track_chan(track_chan),
    .powered(powered), .mode(mode), .data_valid(data_valid),
    .conv_start(conv_start));
  scm_host host (.clk(clk), .dout_o(dout_o), .dout_oe_n(dout_oe_n),
    .track(track), .track_chan(track_chan), .powered(powered),
    .data_valid(data_valid), .mode(mode), .cs_n(cs_n), .sclk(sclk),
    .din(din), .done(done), .obs(obs));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report

  // Notes the expected summary, then runs one frame
  task automatic run(input int n, input logic [15:0] wd,
                     input logic [2:0] m, input logic v,
                     input logic [24:0] mk);
    logic [11:0] r;
    logic [15:0] src;
    r = 12'($urandom);
    frames++;
    @(posedge clk) result <= r;
    src = (cur == SCM_CHAIN) ? stored : {2'b00, ch, ch, r};
    // Channel is only taken by frames of 13 or more falls or a chain exit dummy
    if (n >= 13 || (cur == SCM_CHAIN && n >= 10)) ch = wd[13];
    expq.push_back({mk, ch, v, m, 1'b1, 1'(m != SCM_PDOWN), 1'b1, 1'b0,
                    16'(src >> (16 - n))});
    host.frame(n, wd);
    stored = wd;
    cur    = m;
  endtask : run

  // Random word with channel and keep bits set as asked
  function automatic logic [15:0] rw(input logic c, input logic k);
    logic [15:0] x;
    x     = 16'($urandom);
    x[13] = c;
    x[12] = k;
    return x;
  endfunction : rw

  // Takes the oldest note whenever a frame summary appears
  always @(posedge clk) begin
    if (done) begin
      ent = expq.pop_front();
      `CHK(obs & ent[49:25], ent[24:0] & ent[49:25])
    end
  end

  // One start pulse is expected per chip-select fall
  always @(posedge clk) begin
    if (conv_start === 1'b1) starts++;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    srst = 1'b1;
    init_mode = 2'h0;
    result = '0;
    ch = 1'b0;
    cur = SCM_NORMAL;
    stored = '0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    void'($urandom(32'h999356a9));
    run(16, 16'h0000, SCM_NORMAL, 1'b0, MK_NORX);
    $display("dummy cycle done");
    for (int i = 0; i < 6; i++) begin
      w = rw(i[0], i[0]);
      run(i == 5 ? 14 : 16, w, SCM_NORMAL, 1'b0, MK_NT);
    end
    run(1, rw(1'b0, 1'b0), SCM_NORMAL, 1'b0, MK_NT);
    $display("normal frames done");
    run(2, rw(1'b1, 1'b1), SCM_PDOWN, 1'b0, MK_NT);
    run(9, rw(1'b1, 1'b1), SCM_PDOWN, 1'b0, 25'h07c0000);
    run(1, rw(1'b1, 1'b1), SCM_PDOWN, 1'b0, 25'h07c0000);
    run(16, rw(1'b1, 1'b1), SCM_NORMAL, 1'b0, 25'h17f0000);
    $display("power-down frames done");
    run(16, rw(1'b0, 1'b0), SCM_NORMAL, 1'b0, MK_FULL);
    run(11, rw(1'b1, 1'b1), SCM_CHAIN, 1'b1, 25'h0fdffff);
    run(16, rw(1'b0, 1'b1), SCM_CHAIN, 1'b1, 25'h0fd0000);
    run(16, rw(1'b1, 1'b0), SCM_CHAIN, 1'b1, 25'h0fdffff);
    run(16, rw(1'b0, 1'b0), SCM_NORMAL, 1'b0, MK_NT);
    run(16, rw(1'b1, 1'b1), SCM_NORMAL, 1'b0, MK_NORX);
    run(12, rw(1'b0, 1'b0), SCM_CHAIN, 1'b0, 25'h0fdffff);
    run(11, rw(1'b1, 1'b1), SCM_NORMAL, 1'b0, 25'h0fd0000);
    run(16, rw(1'b0, 1'b0), SCM_NORMAL, 1'b0, MK_FULL);
    $display("chain frames done");
    // Mid-run reset with the power-down strap, then a wake frame
    srst      <= 1'b1;
    init_mode <= 2'h1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    ch  = 1'b0;
    cur = SCM_PDOWN;
    run(16, rw(1'b1, 1'b1), SCM_NORMAL, 1'b0, 25'h17f0000);
    $display("strap frame done");
    repeat (10) @(posedge clk);
    `CHK(starts, frames)
    final_report();
  end
endmodule : scm_ctrl_tb
